/* File: pkg/serial_port_consts.vh */
// constants for the serial control port register block
// assumes inclusion by bare name from design files
`ifndef SERIAL_PORT_CONSTS_VH
`define SERIAL_PORT_CONSTS_VH
`define CMD_DIR_BIT       0
`define CMD_ADDR_LSB      1
`define CMD_ADDR_MSB      4
`define CMD_BURST_BIT     7
`define ADDR_RX_ALARM_MASK   4'h0
`define ADDR_RX_ALARM_STATUS 4'h1
`define ADDR_LCV_COUNT       4'h2
`define ADDR_CKSUM_COUNT     4'h3
`define ADDR_FRAME_COUNT     4'h4
`define ADDR_RX_CONTROL      4'h5
`define ADDR_SHARED_CONTROL  4'h6
`define ADDR_TX_CONTROL      4'h7
`define ADDR_TX_IDLE_1       4'h8
`define ADDR_TX_IDLE_2       4'h9
`define ADDR_TX_IDLE_3       4'ha
`define ADDR_TX_IDLE_4       4'hb
`define ADDR_TX_SPARE        4'hc
`define ADDR_TX_EXTRA        4'hd
`define ADDR_LAST            4'hd
`define ADDR_ZERO            4'h0
`define REG_COUNT            14
`define REG_RESET            8'h00
`define BIT_COUNT_LAST       3'h7
`define TX_CTRL_SPARE_INTL   4
`define TX_CTRL_SPARE_NATL   3
`define TX_CTRL_EXTRA        2
`endif

/* File: src/edge_sync.v */
// two-flop synchroniser with rise and fall detect on the synced level
// assumes input is asynchronous to core_clk
`timescale 1ns/1ns
module edge_sync (
  input  wire core_clk,
  input  wire reset,
  input  wire async_in,
  output reg  level_q,
  output wire rise,
  output wire fall
);
  reg meta_q;
  reg sync_q;

  // first flop feeds only the second; edges come from later stages
  always @(posedge core_clk) begin
    if (reset) begin
      meta_q  <= 1'b0;
      sync_q  <= 1'b0;
      level_q <= 1'b0;
    end else begin
      meta_q  <= async_in;
      sync_q  <= meta_q;
      level_q <= sync_q;
    end
  end

  // edge terms compare the two settled stages
  assign rise = sync_q & ~level_q;
  assign fall = ~sync_q & level_q;
endmodule // edge_sync

/* File: src/serial_control_port_regs.v */
// serial host port giving access to fourteen 8-bit line control registers
// assumes shift clock, chip select and data in are asynchronous pins;
// line-side events arrive as core_clk pulses from the line logic.
// Summary of operation
// RULE1 - first byte after chip select falls is always the command byte
// RULE2 - command bit 0 chooses direction: 0 write, 1 read
// RULE3 - command bits 1 to 4 hold register address, bit 4 msb
// RULE4 - host sends zero in command bits 5 and 6
// RULE5 - burst only when bit 7 set and address field is zero
// RULE6 - command and data bytes shift least significant bit first
// RULE7 - transfers start with chip select low; shift clock ignored when high
// RULE8 - serial input captured on rising shift clock edge
// RULE9 - serial output changes on falling edge, held until next falling
// RULE10 - chip select high aborts transfer and floats serial output
// RULE11 - after command, next eight clocks move one data byte
// RULE12 - serial output stays floating during any write access
// RULE13 - host completes whole burst before raising chip select
// RULE14 - port timing independent of line transmit and receive timing
// RULE15 - tx registers via tx line clock, rx and shared via rx clock
// RULE16 - alarm status is read only; all others read and write
// RULE17 - host writes zero into reserved register bits
// RULE18 - violation count is host-presettable 8-bit event counter
// RULE19 - checksum error count is host-presettable 8-bit event counter
// RULE20 - framing error count is host-presettable event counter
// RULE21 - alarm mask per source; status reports every receive alarm
// RULE22 - four idle select registers mark idle-replaced outgoing timeslots
// RULE23 - tx control enables spare and extra bit register substitution
// RULE24 - burst address steps upward from zero through thirteen
`timescale 1ns/1ns
`include "serial_port_consts.vh"
module serial_control_port_regs (
  input  wire        core_clk,
  input  wire        reset,
  input  wire        port_clock,
  input  wire        chip_select_n,
  input  wire        port_serial_in,
  output reg         port_serial_out,
  output reg         port_serial_out_oe,
  input  wire        tx_line_clock,
  input  wire        rx_line_clock,
  input  wire [7:0]  rx_alarm_level,
  input  wire        line_code_violation,
  input  wire        checksum_error,
  input  wire        framing_error,
  output wire [7:0]  rx_alarm_mask,
  output wire [7:0]  rx_control,
  output wire [7:0]  shared_control,
  output wire [7:0]  tx_control,
  output wire [31:0] tx_idle_select,
  output wire [7:0]  tx_spare_bits,
  output wire [7:0]  tx_extra_bits,
  output wire        spare_intl_enable,
  output wire        spare_natl_enable,
  output wire        extra_enable
);
  localparam ST_IDLE = 2'h0;
  localparam ST_CMD  = 2'h1;
  localparam ST_DATA = 2'h2;
  localparam ST_DONE = 2'h3;

  wire       sclk_lvl;
  wire       sclk_rise;
  wire       sclk_fall;
  wire       cs_n_lvl;
  wire       sdi_lvl;
  wire       tx_line_clock_rise;
  wire       rclk_rise;
  reg  [1:0] state_q;
  reg  [2:0] bit_cnt_q;
  reg  [7:0] shift_q;
  reg        dir_read_q;
  reg        burst_q;
  reg  [3:0] addr_q;
  reg  [7:0] out_byte_q;
  reg        out_armed_q;
  reg        wr_pend_q;
  reg  [3:0] wr_addr_q;
  reg  [7:0] wr_data_q;
  reg  [7:0] regs_q [0:`REG_COUNT-1];
  reg  [7:0] status_q;
  wire [7:0] next_shift;
  wire       wr_is_tx;
  wire       wr_go;
  reg  [7:0] rd_data;

  // RULE14 port pins resynchronised
  edge_sync u_sclk (
    .core_clk (core_clk),
    .reset    (reset),
    .async_in (port_clock),
    .level_q  (sclk_lvl),
    .rise     (sclk_rise),
    .fall     (sclk_fall)
  );
  edge_sync u_cs (
    .core_clk (core_clk),
    .reset    (reset),
    .async_in (chip_select_n),
    .level_q  (cs_n_lvl),
    .rise     (),
    .fall     ()
  );
  // data in delayed like the shift clock so rising-edge samples line up
  edge_sync u_sdi (
    .core_clk (core_clk),
    .reset    (reset),
    .async_in (port_serial_in),
    .level_q  (sdi_lvl),
    .rise     (),
    .fall     ()
  );
  edge_sync u_tx_line_clock (
    .core_clk (core_clk),
    .reset    (reset),
    .async_in (tx_line_clock),
    .level_q  (),
    .rise     (tx_line_clock_rise),
    .fall     ()
  );
  edge_sync u_rclk (
    .core_clk (core_clk),
    .reset    (reset),
    .async_in (rx_line_clock),
    .level_q  (),
    .rise     (rclk_rise),
    .fall     ()
  );

  // RULE6 lsb arrives first, so shift toward bit 0
  assign next_shift = {sdi_lvl, shift_q[7:1]};

  // read mux; status register lives outside the writable array
  always @* begin
    rd_data = `REG_RESET;
    if (addr_q == `ADDR_RX_ALARM_STATUS)
      rd_data = status_q;
    else if (addr_q <= `ADDR_LAST)
      rd_data = regs_q[addr_q];
  end

  // port sequencer: command byte, then data bytes
  always @(posedge core_clk) begin
    if (reset) begin
      state_q     <= ST_IDLE;
      bit_cnt_q   <= 3'h0;
      shift_q     <= 8'h00;
      dir_read_q  <= 1'b0;
      burst_q     <= 1'b0;
      addr_q      <= 4'h0;
      out_byte_q  <= 8'h00;
      out_armed_q <= 1'b0;
      port_serial_out    <= 1'b0;
      port_serial_out_oe <= 1'b0;
    end else if (cs_n_lvl) begin
      // RULE10 abort and float on deselect
      // RULE7 shift clock ignored while deselected
      state_q            <= ST_CMD;
      bit_cnt_q          <= 3'h0;
      out_armed_q        <= 1'b0;
      port_serial_out_oe <= 1'b0;
    end else begin
      if (state_q == ST_IDLE)
        state_q <= ST_CMD;
      // RULE8 capture on rising shift edge
      if (sclk_rise) begin
        shift_q   <= next_shift;
        bit_cnt_q <= bit_cnt_q + 3'h1;
        case (state_q)
          // RULE1 first byte is the command
          ST_CMD: begin
            if (bit_cnt_q == `BIT_COUNT_LAST) begin
              // RULE2 direction from bit 0
              dir_read_q <= next_shift[`CMD_DIR_BIT];
              // RULE3 address bits 4..1
              addr_q <= next_shift[`CMD_ADDR_MSB:`CMD_ADDR_LSB];
              // RULE5 burst needs zero address
              burst_q <= next_shift[`CMD_BURST_BIT] &
                (next_shift[`CMD_ADDR_MSB:`CMD_ADDR_LSB] == `ADDR_ZERO);
              state_q <= ST_DATA;
              out_armed_q <= next_shift[`CMD_DIR_BIT];
            end
          end
          // RULE11 eight clocks per data byte
          ST_DATA: begin
            if (bit_cnt_q == `BIT_COUNT_LAST) begin
              // RULE24 burst steps address upward
              if (burst_q && addr_q != `ADDR_LAST) begin
                addr_q      <= addr_q + 4'h1;
                out_armed_q <= dir_read_q;
              end else begin
                state_q <= ST_DONE;
              end
            end
          end
          default: begin
            state_q <= state_q;
          end
        endcase
      end
      // RULE9 output moves on falling edges only
      if (sclk_fall) begin
        if (out_armed_q && state_q == ST_DATA) begin
          // first fall after the command loads the byte, lsb out
          port_serial_out    <= rd_data[0];
          out_byte_q         <= {1'b0, rd_data[7:1]};
          out_armed_q        <= 1'b0;
          port_serial_out_oe <= 1'b1;
        end else if (state_q == ST_DATA && dir_read_q) begin
          port_serial_out <= out_byte_q[0];
          out_byte_q      <= {1'b0, out_byte_q[7:1]};
        end else begin
          // RULE12 no drive during writes or after the last byte
          port_serial_out_oe <= 1'b0;
        end
      end
    end
  end

  // a completed write byte waits for its line clock edge
  always @(posedge core_clk) begin
    if (reset) begin
      wr_pend_q <= 1'b0;
      wr_addr_q <= 4'h0;
      wr_data_q <= 8'h00;
    end else if (sclk_rise && !cs_n_lvl && state_q == ST_DATA &&
                 !dir_read_q && bit_cnt_q == `BIT_COUNT_LAST) begin
      wr_pend_q <= 1'b1;
      wr_addr_q <= addr_q;
      wr_data_q <= next_shift;
    end else if (wr_go) begin
      wr_pend_q <= 1'b0;
    end
  end

  // RULE15 tx addresses commit on tx clock, rx and shared on rx clock
  assign wr_is_tx = (wr_addr_q >= `ADDR_TX_CONTROL);
  assign wr_go    = wr_pend_q & (wr_is_tx ? tx_line_clock_rise : rclk_rise);

  // register array; counters share the storage and step on events
  genvar gi;
  generate
    for (gi = 0; gi < `REG_COUNT; gi = gi + 1) begin : g_reg
      always @(posedge core_clk) begin
        if (reset)
          regs_q[gi] <= `REG_RESET;
        // RULE16 status address has no storage writes
        else if (wr_go && wr_addr_q == gi &&
                 gi != `ADDR_RX_ALARM_STATUS)
          regs_q[gi] <= wr_data_q;
        // RULE18 violation counter
        else if (gi == `ADDR_LCV_COUNT && line_code_violation)
          regs_q[gi] <= regs_q[gi] + 8'h01;
        // RULE19 checksum counter
        else if (gi == `ADDR_CKSUM_COUNT && checksum_error)
          regs_q[gi] <= regs_q[gi] + 8'h01;
        // RULE20 framing counter
        else if (gi == `ADDR_FRAME_COUNT && framing_error)
          regs_q[gi] <= regs_q[gi] + 8'h01;
      end
    end
  endgenerate

  // RULE21 status follows each alarm source
  always @(posedge core_clk) begin
    if (reset)
      status_q <= `REG_RESET;
    else
      status_q <= rx_alarm_level;
  end

  // RULE21 mask out per source
  assign rx_alarm_mask  = regs_q[`ADDR_RX_ALARM_MASK];
  assign rx_control     = regs_q[`ADDR_RX_CONTROL];
  assign shared_control = regs_q[`ADDR_SHARED_CONTROL];
  assign tx_control     = regs_q[`ADDR_TX_CONTROL];
  // RULE22 idle slot map, register 1 lowest
  assign tx_idle_select = {regs_q[`ADDR_TX_IDLE_4], regs_q[`ADDR_TX_IDLE_3],
                           regs_q[`ADDR_TX_IDLE_2], regs_q[`ADDR_TX_IDLE_1]};
  assign tx_spare_bits  = regs_q[`ADDR_TX_SPARE];
  assign tx_extra_bits  = regs_q[`ADDR_TX_EXTRA];
  // RULE23 substitution enables
  assign spare_intl_enable = tx_control[`TX_CTRL_SPARE_INTL];
  assign spare_natl_enable = tx_control[`TX_CTRL_SPARE_NATL];
  assign extra_enable      = tx_control[`TX_CTRL_EXTRA];
endmodule // serial_control_port_regs

/* File: testbench/serial_port_props.sv */
// pin-level assertions for the serial control port register block
// assumes raw port pins sampled by core_clk, host half period 8 cycles
`timescale 1ns/1ns
module serial_port_props (
  input logic       core_clk,
  input logic       reset,
  input logic       port_clock,
  input logic       chip_select_n,
  input logic       port_serial_in,
  input logic       port_serial_out,
  input logic       port_serial_out_oe,
  input logic [7:0] tx_control,
  input logic       spare_intl_enable,
  input logic       spare_natl_enable,
  input logic       extra_enable
);
  logic [7:0] cmd_q;
  logic [7:0] nrise_q;
  logic [3:0] age_q;
  logic       clk_q;
  default clocking @(posedge core_clk); endclocking
  default disable iff (reset);
  // shadow command byte, shift rises per frame, age since last fall
  always @(posedge core_clk) begin
    clk_q <= port_clock;
    if (reset || chip_select_n) begin
      nrise_q <= 8'h00;
    end else if (port_clock && !clk_q) begin
      nrise_q <= nrise_q + 8'h01;
      if (nrise_q < 8'h08) begin
        cmd_q <= {port_serial_in, cmd_q[7:1]};
      end
    end
    if (reset || (clk_q && !port_clock)) begin
      age_q <= 4'h0;
    end else if (age_q != 4'hf) begin
      age_q <= age_q + 4'h1;
    end
  end
  sequence s_cs_high;
    chip_select_n [*6];
  endsequence
  sequence s_out_moved;
    port_serial_out_oe && $past(port_serial_out_oe) && $changed(port_serial_out);
  endsequence
  property p_cs_idle; s_cs_high |-> !port_serial_out_oe; endproperty
  a_cs_idle: assert property (p_cs_idle) else $error("out on, cs idle");
  property p_cmd_quiet; !chip_select_n && nrise_q < 8 |-> !port_serial_out_oe;
  endproperty
  a_cmd_quiet: assert property (p_cmd_quiet) else $error("out in cmd");
  property p_oe_start; $rose(port_serial_out_oe) |-> nrise_q == 8 && cmd_q[0];
  endproperty
  a_oe_start: assert property (p_oe_start) else $error("bad out start");
  property p_burst; port_serial_out_oe && nrise_q > 16 |->
    cmd_q[7] && cmd_q[4:1] == 4'h0; endproperty
  a_burst: assert property (p_burst) else $error("out past one byte");
  property p_out_hold; s_out_moved |-> age_q <= 7; endproperty
  a_out_hold: assert property (p_out_hold) else $error("out moved late");
  property p_intl; spare_intl_enable == tx_control[4]; endproperty
  a_intl: assert property (p_intl) else $error("intl enable");
  property p_natl; spare_natl_enable == tx_control[3]; endproperty
  a_natl: assert property (p_natl) else $error("natl enable");
  property p_extra; extra_enable == tx_control[2]; endproperty
  a_extra: assert property (p_extra) else $error("extra enable");
endmodule // serial_port_props
bind serial_control_port_regs serial_port_props props (.core_clk, .reset,
  .port_clock, .chip_select_n, .port_serial_in, .port_serial_out,
  .port_serial_out_oe, .tx_control, .spare_intl_enable,
  .spare_natl_enable, .extra_enable);

/* File: testbench/host_port_model.sv */
// host model driving the serial shift port of the register block
// assumes core_clk paced shift clock, half period of 8 core cycles
`timescale 1ns/1ns
module host_port_model (
  input  logic core_clk,
  input  logic port_serial_out,
  input  logic port_serial_out_oe,
  output logic port_clock,
  output logic chip_select_n,
  output logic port_serial_in
);
  logic [7:0] wbuf [14];
  logic [7:0] rbuf [14];
  // idle: shift clock parked high, no frame
  initial begin
    port_clock = 1'b1;
    chip_select_n = 1'b1;
    port_serial_in = 1'b0;
  end
  // lsb first, data moves on fall
  task automatic shift(input logic [7:0] b, output logic [7:0] r);
    for (int i = 0; i < 8; i++) begin
      port_clock <= 1'b0;
      port_serial_in <= b[i];
      repeat (8) @(posedge core_clk);
      // a floating output reads unknown so it never matches
      r[i] = port_serial_out_oe ? port_serial_out : 1'bx;
      port_clock <= 1'b1;
      repeat (8) @(posedge core_clk);
    end
  endtask
  // callers keep command bits 5 and 6 at zero
  // callers write zero into reserved register bits
  task automatic xfer(input logic [7:0] cmd, input int n);
    logic [7:0] junk;
    chip_select_n <= 1'b0;
    repeat (8) @(posedge core_clk);
    shift(cmd, junk);
    for (int k = 0; k < n; k++) shift(wbuf[k], rbuf[k]);
    chip_select_n <= 1'b1;
    // released line shows the inverse rather than the last bit
    port_serial_in <= ~port_serial_in;
    repeat (12) @(posedge core_clk);
  endtask
endmodule // host_port_model

/* File: testbench/test_serial_control_port_regs.sv */
// self-checking bench for the serial control port register block
// assumes the host model paces frames; line clocks run free, unrelated
`timescale 1ns/1ns
module test_serial_control_port_regs;
  logic        core_clk = 1'b0;
  logic        reset = 1'b1;
  logic        txc = 1'b0;
  logic        rxc = 1'b0;
  logic [7:0]  alarm = 8'h5a;
  logic [2:0]  ev = 3'h0;
  logic        pclk, csn, sin, sout, oe;
  logic [7:0]  rx_control, tx_control;
  logic [31:0] idle;
  int          mismatches = 0;
  int          checks = 0;
  // core clock and the two line clocks
  always #10 core_clk = ~core_clk;
  always #80 txc = ~txc;
  always #83 rxc = ~rxc;
  host_port_model host (.core_clk(core_clk), .port_serial_out(sout),
    .port_serial_out_oe(oe), .port_clock(pclk), .chip_select_n(csn),
    .port_serial_in(sin));
  serial_control_port_regs dut (.core_clk(core_clk), .reset(reset),
    .port_clock(pclk), .chip_select_n(csn), .port_serial_in(sin),
    .port_serial_out(sout), .port_serial_out_oe(oe), .tx_line_clock(txc),
    .rx_line_clock(rxc), .rx_alarm_level(alarm),
    .line_code_violation(ev[0]), .checksum_error(ev[1]),
    .framing_error(ev[2]), .rx_alarm_mask(), .rx_control(rx_control),
    .shared_control(), .tx_control(tx_control), .tx_idle_select(idle),
    .tx_spare_bits(), .tx_extra_bits(), .spare_intl_enable(),
    .spare_natl_enable(), .extra_enable());
  task automatic chk(input string nm, input logic [31:0] e, g);
    checks++;
    if (g !== e) begin
      mismatches++;
      $display("[FAIL] %s expected %h seen %h", nm, e, g);
    end
  endtask
  task automatic rd(input logic [3:0] a, input logic [7:0] e);
    host.xfer({3'h0, a, 1'b1}, 1);
    chk("single read", 32'(e), 32'(host.rbuf[0]));
  endtask
  task automatic print_verdict;
    $display("checks %0d mismatches %0d", checks, mismatches);
    if (mismatches == 0 && checks > 0)
      $display("All checks passed");
    else
      $display("Checks failed");
    $finish;
  endtask
  // watchdog well beyond the expected 16300 cycles
  initial begin
    repeat (60000) @(posedge core_clk);
    mismatches++;
    print_verdict();
  end
  // main sequence
  initial begin
    repeat (3) @(posedge core_clk);
    reset <= 1'b0;
    repeat (10) @(posedge core_clk);
    host.xfer(8'h81, 14);
    for (int k = 0; k < 14; k++)
      chk("reset burst", 32'(k == 1 ? 8'h5a : 8'h00), 32'(host.rbuf[k]));
    for (int k = 0; k < 14; k++) host.wbuf[k] = 8'(k * 17 + 3);
    host.xfer(8'h80, 14);
    alarm <= 8'ha5;
    host.xfer(8'h81, 14);
    for (int k = 0; k < 14; k++)
      chk("burst", 32'(k == 1 ? 8'ha5 : 8'(k * 17 + 3)), 32'(host.rbuf[k]));
    chk("tx_control", 32'h0000_007a, 32'(tx_control));
    chk("rx_control", 32'h0000_0058, 32'(rx_control));
    chk("idle", 32'hbead_9c8b, idle);
    for (int a = 0; a < 16; a++) begin
      host.wbuf[0] = 8'(8'hc3 ^ a);
      host.xfer({3'h0, 4'(a), 1'b0}, 1);
      rd(4'(a), a == 1 ? 8'ha5 : a > 13 ? 8'h00 : 8'(8'hc3 ^ a));
    end
    for (int c = 0; c < 3; c++) begin
      host.wbuf[0] = 8'hfe;
      host.xfer({3'h0, 4'(c + 2), 1'b0}, 1);
      repeat (3) begin
        ev <= 3'(1 << c);
        @(posedge core_clk);
        ev <= 3'h0;
        @(posedge core_clk);
      end
      rd(4'(c + 2), 8'h01);
    end
    print_verdict();
  end
endmodule // test_serial_control_port_regs
